// File: shared/eirb_regs.svh
// Timing and reset constants for the interrupt, reset and boot pin block
`ifndef EIRB_REGS_SVH
`define EIRB_REGS_SVH
`define EIRB_RESET_STRETCH_CYCLES 8'h40
`define EIRB_BOOT_ON_CHIP 1'b0
`define EIRB_BOOT_OFF_CHIP 1'b1
`define EIRB_SHARED_PIN_SERIAL 1'b0
`define EIRB_SHARED_PIN_SPI 1'b1
`define EIRB_TRIG_LEVEL 1'b0
`define EIRB_TRIG_EDGE 1'b1
`endif

// File: shared/eirb_pkg.sv
// Types for the interrupt, reset and boot pin block
package eirb_pkg;
    typedef enum logic [2:0] {
        EIRB_RST_HOLD = 3'b001,
        EIRB_RST_STRETCH = 3'b010,
        EIRB_RST_RUN = 3'b100
    } eirb_rst_state_type;
    typedef struct packed {
        logic [1:0] trig_edge;
        logic [1:0] clear;
    } eirb_irq_ctrl_type;
    typedef struct packed {
        logic spi_select;
        logic spi_master;
    } eirb_pin_ctrl_type;
endpackage

// File: hdl/eirb_sys_pins.sv
// Interrupt request, hardware reset, boot select and shared pin logic
`timescale 1ns/1ps
`default_nettype none
`include "eirb_regs.svh"
module eirb_sys_pins
    import eirb_pkg::*;
(
    // Clock and power-on reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Pins
    input wire logic ext_irq_a_n_in,
    input wire logic ext_irq_b_n_in,
    input wire logic hw_reset_n_in,
    input wire logic test_reset_n_in,
    input wire logic boot_source_select_in,
    input wire logic shared_pin_in,
    // Core control
    input wire eirb_irq_ctrl_type irq_ctrl_in,
    input wire eirb_pin_ctrl_type pin_ctrl_in,
    input wire logic in_stop_in,
    // Core status
    output logic [1:0] irq_request_out,
    output logic stop_wake_out,
    output logic core_reset_out,
    output logic debug_reset_out,
    output logic boot_off_chip_out,
    output logic serial1_receive_out,
    output logic spi0_slave_select_n_out,
    output logic spi0_mode_fault_out
);
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] irq_sync;
    logic [1:0] irq_prev;
    logic [1:0] edge_pending;
    logic [1:0] fall;
    logic [7:0] stretch_count;
    eirb_rst_state_type rst_state;
    eirb_rst_state_type next_rst_state;
    logic boot_captured;

    // Two-stage synchronisers: bit 0 first stage, bit 1 second stage
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= 2'h3;
            sync_b <= 2'h3;
        end else begin
            sync_a <= {sync_a[0], ext_irq_a_n_in};
            sync_b <= {sync_b[0], ext_irq_b_n_in};
        end
    end
    // Same two-stage scheme for reset, boot, test reset and shared pin
    logic [1:0] rst_sync;
    logic [1:0] boot_sync;
    logic [1:0] trst_sync;
    logic [1:0] shared_sync;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rst_sync <= 2'h0;
            boot_sync <= 2'h0;
            trst_sync <= 2'h0;
            shared_sync <= 2'h3;
        end else begin
            rst_sync <= {rst_sync[0], hw_reset_n_in};
            boot_sync <= {boot_sync[0], boot_source_select_in};
            trst_sync <= {trst_sync[0], test_reset_n_in};
            shared_sync <= {shared_sync[0], shared_pin_in};
        end
    end

    assign irq_sync = {sync_b[1], sync_a[1]};
    assign fall = irq_prev & ~irq_sync;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_prev <= 2'h3;
        end else begin
            irq_prev <= irq_sync;
        end
    end

    // Edge latch: a new edge wins over a clear in the same cycle
    // Only edge-mode inputs latch; a bit latched before a switch to level mode stays until cleared
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            edge_pending <= 2'h0;
        end else if (core_reset_out) begin
            edge_pending <= 2'h0;
        end else begin
            edge_pending <= (edge_pending & ~irq_ctrl_in.clear)
                | (fall & irq_ctrl_in.trig_edge);
        end
    end

    // Per-input trigger choice, registered onto the output
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_request_out <= 2'h0;
        end else if (core_reset_out) begin
            irq_request_out <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (irq_ctrl_in.trig_edge[i] == `EIRB_TRIG_EDGE) begin
                    irq_request_out[i] <= edge_pending[i] | fall[i];
                end else begin
                    irq_request_out[i] <= ~irq_sync[i];
                end
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stop_wake_out <= 1'b0;
        end else begin
            stop_wake_out <= in_stop_in & ~irq_sync[0]
                & ~core_reset_out;
        end
    end

    // Reset sequencer
    always_comb begin
        next_rst_state = rst_state;
        case (rst_state)
            EIRB_RST_HOLD: begin
                if (rst_sync[1]) begin
                    next_rst_state = EIRB_RST_STRETCH;
                end
            end
            EIRB_RST_STRETCH: begin
                if (!rst_sync[1]) begin
                    next_rst_state = EIRB_RST_HOLD;
                end else if (stretch_count ==
                             `EIRB_RESET_STRETCH_CYCLES - 8'h01) begin
                    next_rst_state = EIRB_RST_RUN;
                end
            end
            EIRB_RST_RUN: begin
                if (!rst_sync[1]) begin
                    next_rst_state = EIRB_RST_HOLD;
                end
            end
            default: next_rst_state = EIRB_RST_HOLD;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rst_state <= EIRB_RST_HOLD;
        end else begin
            rst_state <= next_rst_state;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stretch_count <= 8'h00;
        end else if (rst_state == EIRB_RST_STRETCH) begin
            stretch_count <= stretch_count + 8'h01;
        end else begin
            stretch_count <= 8'h00;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            core_reset_out <= 1'b1;
        end else begin
            core_reset_out <= (next_rst_state != EIRB_RST_RUN);
        end
    end

    // Debug reset follows only the test reset pin
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            debug_reset_out <= 1'b1;
        end else begin
            debug_reset_out <= ~trst_sync[1];
        end
    end

    // Boot source caught on the release edge of the reset pin
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            boot_captured <= `EIRB_BOOT_ON_CHIP;
        end else if (rst_state == EIRB_RST_HOLD && rst_sync[1]) begin
            boot_captured <= boot_sync[1];
        end
    end
    assign boot_off_chip_out = (boot_captured == `EIRB_BOOT_OFF_CHIP);

    // Shared pin routing
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            serial1_receive_out <= 1'b1;
            spi0_slave_select_n_out <= 1'b1;
            spi0_mode_fault_out <= 1'b0;
        end else if (core_reset_out ||
                     pin_ctrl_in.spi_select == `EIRB_SHARED_PIN_SERIAL) begin
            serial1_receive_out <= shared_sync[1];
            spi0_slave_select_n_out <= 1'b1;
            spi0_mode_fault_out <= 1'b0;
        end else begin
            serial1_receive_out <= 1'b1;
            spi0_slave_select_n_out <= pin_ctrl_in.spi_master ?
                1'b1 : shared_sync[1];
            spi0_mode_fault_out <= pin_ctrl_in.spi_master
                & ~shared_sync[1];
        end
    end

    // Checker helper: edges seen with reset pin high and core reset on
    logic [7:0] release_age;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            release_age <= 8'h00;
        end else if (!rst_sync[1] || !core_reset_out) begin
            release_age <= 8'h00;
        end else if (release_age != 8'hff) begin
            release_age <= release_age + 8'h01;
        end
    end

    // Assertions
    a_reset_held_low: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !rst_sync[1] |=> core_reset_out)
        else $error("core reset released while reset pin low");
    a_reset_stretch_len: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $rose(rst_sync[1]) && rst_state == EIRB_RST_HOLD
        |-> core_reset_out [*8])
        else $error("core reset released too early");
    a_reset_release_bound: assert property (
        @(posedge clock_in) disable iff (rst_in)
        rst_state == EIRB_RST_HOLD && rst_sync[1]
        |-> ##[1:65] (!core_reset_out || !rst_sync[1]))
        else $error("core reset not released after stretch");
    a_reset_stretch_exact: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $fell(core_reset_out)
        |-> release_age == `EIRB_RESET_STRETCH_CYCLES + 8'h01)
        else $error("core reset stretch length wrong");
    a_boot_capture: assert property (
        @(posedge clock_in) disable iff (rst_in)
        rst_state == EIRB_RST_HOLD && rst_sync[1]
        |=> boot_off_chip_out == $past(boot_sync[1]))
        else $error("boot source not captured on release");
    a_boot_held: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !(rst_state == EIRB_RST_HOLD && rst_sync[1])
        |=> $stable(boot_off_chip_out))
        else $error("boot source changed outside release");
    a_irq_sync_path: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !core_reset_out && irq_ctrl_in.trig_edge[0] == `EIRB_TRIG_LEVEL
        |=> irq_request_out[0] == !$past(ext_irq_a_n_in, 3))
        else $error("interrupt A skipped a synchroniser stage");
    a_edge_pending: assert property (
        @(posedge clock_in) disable iff (rst_in)
        fall[0] && !core_reset_out
        && irq_ctrl_in.trig_edge[0] == `EIRB_TRIG_EDGE |=> edge_pending[0])
        else $error("falling edge on A was lost");
    a_edge_clear: assert property (
        @(posedge clock_in) disable iff (rst_in)
        irq_ctrl_in.clear[1] && !fall[1] |=> !edge_pending[1])
        else $error("pending edge on B not cleared");
    a_level_request: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !core_reset_out && irq_ctrl_in.trig_edge[1] == `EIRB_TRIG_LEVEL
        && !irq_sync[1] |=> irq_request_out[1] || core_reset_out)
        else $error("level request on B not raised");
    a_stop_wake: assert property (
        @(posedge clock_in) disable iff (rst_in)
        in_stop_in && !irq_sync[0] && !core_reset_out |=> stop_wake_out)
        else $error("no wake from Stop on interrupt A");
    a_debug_kept: assert property (
        @(posedge clock_in) disable iff (rst_in)
        trst_sync[1] |=> !debug_reset_out)
        else $error("debug reset asserted without test reset");
    a_shared_default: assert property (
        @(posedge clock_in) disable iff (rst_in)
        core_reset_out |=> spi0_slave_select_n_out)
        else $error("slave select active during reset");
    a_serial_default: assert property (
        @(posedge clock_in) disable iff (rst_in)
        core_reset_out
        |=> serial1_receive_out == $past(shared_sync[1]))
        else $error("shared pin not routed to serial receive in reset");
    a_master_ss: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !core_reset_out && pin_ctrl_in.spi_select == `EIRB_SHARED_PIN_SPI
        && pin_ctrl_in.spi_master |=> spi0_slave_select_n_out)
        else $error("slave select active in master mode");
endmodule
`default_nettype wire

// File: verification/eirb_pin_model.sv
// Board-side model driving the interrupt, reset, boot and shared pins
`timescale 1ns/1ps
`default_nettype none
module eirb_pin_model (
    // Clock
    input wire logic clock_in,
    // Pins toward the block
    output logic [1:0] irq_n_out,
    output logic hw_reset_n_out,
    output logic test_reset_n_out,
    output logic boot_out,
    output logic shared_out
);
    // Pull-ups hold the pins high until driven, except the boot pin, which starts low
    initial begin
        irq_n_out = 2'h3;
        hw_reset_n_out = 1'b1;
        test_reset_n_out = 1'b1;
        boot_out = 1'b0;
        shared_out = 1'b1;
    end
    task automatic irq(input int i, input logic v);
        @(posedge clock_in);
        irq_n_out <= i ? {v, irq_n_out[0]} : {irq_n_out[1], v};
    endtask
    // Full reset pulls both resets, debug reset only the main one
    task automatic reset_pin(input logic low, input logic full);
        @(posedge clock_in);
        hw_reset_n_out <= !low;
        test_reset_n_out <= !(low && full);
    endtask
    task automatic boot(input logic v);
        @(posedge clock_in);
        boot_out <= v;
    endtask
    task automatic shared(input logic v);
        @(posedge clock_in);
        shared_out <= v;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_eirb_sys_pins.sv
// Self-checking bench for the interrupt, reset, boot and shared pin block
`timescale 1ns/1ps
`default_nettype none
`include "eirb_regs.svh"
module tb_eirb_sys_pins;
    import eirb_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] irq_n;
    logic hw_reset_n, test_reset_n, boot, shared;
    eirb_irq_ctrl_type irq_ctrl = '0;
    eirb_pin_ctrl_type pin_ctrl = '0;
    logic in_stop = 1'b0;
    logic [1:0] irq_req;
    logic wake, core_rst, dbg_rst, boot_off, ser_rx, ss_n, fault;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 clock_in = ~clock_in;
    eirb_pin_model pins (.clock_in(clock_in), .irq_n_out(irq_n),
        .hw_reset_n_out(hw_reset_n), .test_reset_n_out(test_reset_n),
        .boot_out(boot), .shared_out(shared));
    eirb_sys_pins DUT (.clock_in(clock_in), .rst_in(rst_in),
        .ext_irq_a_n_in(irq_n[0]), .ext_irq_b_n_in(irq_n[1]),
        .hw_reset_n_in(hw_reset_n), .test_reset_n_in(test_reset_n),
        .boot_source_select_in(boot), .shared_pin_in(shared),
        .irq_ctrl_in(irq_ctrl), .pin_ctrl_in(pin_ctrl),
        .in_stop_in(in_stop), .irq_request_out(irq_req),
        .stop_wake_out(wake), .core_reset_out(core_rst),
        .debug_reset_out(dbg_rst), .boot_off_chip_out(boot_off),
        .serial1_receive_out(ser_rx), .spi0_slave_select_n_out(ss_n),
        .spi0_mode_fault_out(fault));
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    // Boot pin flips after release; the latched value must not follow
    task automatic test_reset_boot(input logic bv, input logic full);
        int n;
        n = 0;
        pins.boot(bv);
        pins.reset_pin(1'b1, full);
        tick(100);
        chk("core_reset_held", 1'b1, core_rst);
        chk("debug_reset", full, dbg_rst);
        chk("ss_in_reset", 1'b1, ss_n);
        chk("serial_in_reset", 1'b0, ser_rx);
        pins.reset_pin(1'b0, full);
        while (core_rst === 1'b1 && n < 200) begin
            pins.boot(n >= 10 ? !bv : bv);
            #1;
            n++;
        end
        chk("stretch_len", 1'b1,
            1'(n == int'(`EIRB_RESET_STRETCH_CYCLES) + 3));
        chk("boot_latched", bv, boot_off);
        chk("debug_released", 1'b0, dbg_rst);
    endtask
    task automatic test_spi();
        tick(4);
        chk("ss_selected", 1'b0, ss_n);
        chk("serial_idle", 1'b1, ser_rx);
        chk("no_fault_slave", 1'b0, fault);
        @(posedge clock_in);
        pin_ctrl.spi_master <= 1'b1;
        tick(4);
        chk("mode_fault", 1'b1, fault);
        chk("ss_master", 1'b1, ss_n);
        @(posedge clock_in);
        pin_ctrl <= '0;
        tick(4);
        chk("serial_rx", 1'b0, ser_rx);
        chk("ss_unused", 1'b1, ss_n);
    endtask
    task automatic test_wake();
        @(posedge clock_in);
        in_stop <= 1'b1;
        tick(4);
        chk("wake_idle", 1'b0, wake);
        pins.irq(0, 1'b0);
        tick(4);
        chk("wake_on_irq", 1'b1, wake);
        pins.irq(0, 1'b1);
        @(posedge clock_in);
        in_stop <= 1'b0;
        tick(4);
        chk("wake_cleared", 1'b0, wake);
    endtask
    // Clear pulse meeting a fresh edge: the edge must stay pending
    task automatic test_clear_race();
        pins.irq(0, 1'b0);
        repeat (2) @(posedge clock_in);
        irq_ctrl.clear[0] <= 1'b1;
        @(posedge clock_in);
        irq_ctrl.clear[0] <= 1'b0;
        pins.irq(0, 1'b1);
        tick(4);
        chk("edge_beats_clear", 1'b1, irq_req[0]);
        @(posedge clock_in);
        irq_ctrl.clear[0] <= 1'b1;
        @(posedge clock_in);
        irq_ctrl.clear[0] <= 1'b0;
        tick(4);
        chk("race_cleared", 1'b0, irq_req[0]);
    endtask
    task automatic test_irq(input int i, input logic edge_mode);
        @(posedge clock_in);
        irq_ctrl.trig_edge[i] <= edge_mode;
        pins.irq(i, 1'b0);
        tick(2);
        chk("irq_sync_delay", 1'b0, irq_req[i]);
        tick(2);
        chk("irq_assert", 1'b1, irq_req[i]);
        pins.irq(i, 1'b1);
        tick(4);
        chk("irq_after_rise", edge_mode, irq_req[i]);
        @(posedge clock_in);
        irq_ctrl.clear[i] <= 1'b1;
        @(posedge clock_in);
        irq_ctrl.clear[i] <= 1'b0;
        tick(4);
        chk("irq_cleared", 1'b0, irq_req[i]);
    endtask
    initial begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        pin_ctrl.spi_select <= 1'b1;
        pins.shared(1'b0);
        test_reset_boot(1'b1, 1'b0);
        test_spi();
        test_reset_boot(1'b0, 1'b1);
        test_wake();
        for (int i = 0; i < 2; i++) begin
            test_irq(i, 1'b0);
            test_irq(i, 1'b1);
        end
        test_clear_race();
        end_of_test();
    end
endmodule
`default_nettype wire
